// ===== hdl/oscd_pkg.sv
// Types shared by the oscillator select and clock divider modules.
// Assumes the constants of oscd_regs.svh.
package oscd_pkg;

    typedef enum logic [2:0] {
        SRC_FAST_RC      = 3'h0,
        SRC_FAST_RC_PLL  = 3'h1,
        SRC_PRIMARY      = 3'h2,
        SRC_PRIMARY_PLL  = 3'h3,
        SRC_SECONDARY    = 3'h4,
        SRC_LOW_POWER_RC = 3'h5,
        SRC_RC_DIV16     = 3'h6,
        SRC_RC_DIVN      = 3'h7
    } oscd_src_t;

    typedef enum logic [1:0] {
        SW_IDLE,
        SW_WAIT_LOCK,
        SW_SETTLE
    } oscd_sw_state_t;

    typedef struct packed {
        oscd_sw_state_t state;
        logic [3:0]     cnt;
        logic           begin_sw;
        logic           done;
        logic           abort;
    } oscd_seq_t;

    typedef struct packed {
        logic        cfg_loaded;
        logic [1:0]  sw_mon;
        logic [1:0]  submode;
        logic        primary_sel;
        logic [2:0]  cur_src;
        logic [2:0]  req_src;
        logic        sw_lock;
        logic        pin_lock;
        logic        fail;
        logic        secondary_oscillator_en;
        logic        sw_req;
        logic        go;
        logic        recover_on_interrupt;
        logic [2:0]  doze;
        logic        red_en;
        logic [2:0]  rc_post;
        logic [1:0]  pll_post;
        logic [4:0]  pll_pre;
        logic [8:0]  pll_mul;
        logic [1:0]  lock_sync;
        logic [1:0]  fail_sync;
        logic        fail_seen;
        logic        pll_lock;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [2:0]  red_shift;
        logic [8:0]  rc_div;
        logic [5:0]  pll_n1;
        logic [3:0]  pll_n2;
        logic [9:0]  pll_m;
        logic [1:0]  fcy_div;
    } oscd_top_t;

endpackage

// ===== hdl/oscd_regs.svh
// Register offsets, field positions, reset values and counts of the
// oscillator select and clock divider block.
// Assumes a 32-bit APB with one aligned word per register.
`ifndef OSCD_REGS_SVH
`define OSCD_REGS_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define OSCD_OFF_OSC_CTRL     12'h000
`define OSCD_OFF_CLK_DIV      12'h004
`define OSCD_OFF_PLL_FBD      12'h008

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define OSCD_CUR_SRC_LSB      12
`define OSCD_REQ_SRC_LSB      8
`define OSCD_SW_LOCK_BIT      7
`define OSCD_PIN_LOCK_BIT     6
`define OSCD_PLL_LOCK_BIT     5
`define OSCD_FAIL_BIT         3
`define OSCD_SECONDARY_OSCILLATOR_EN_BIT      1
`define OSCD_SW_REQ_BIT       0
`define OSCD_ROI_BIT          15
`define OSCD_DOZE_LSB         12
`define OSCD_RED_EN_BIT       11
`define OSCD_RC_POST_LSB      8
`define OSCD_PLL_POST_LSB     6
`define OSCD_PLL_PRE_LSB      0

// ------------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------------
`define OSCD_RST_DOZE         3'h3
`define OSCD_RST_RC_POST      3'h0
`define OSCD_RST_PLL_POST     2'h1
`define OSCD_RST_PLL_PRE      5'h00
`define OSCD_RST_PLL_MUL      9'h030
`define OSCD_RST_SRC          3'h7
`define OSCD_SW_MON_LOCKABLE  2'h1
`define OSCD_SETTLE_CYCLES    4'ha
`define OSCD_FCY_DIV          2'h2

`endif

// ===== hdl/oscd_switch_if.sv
// Carrier between the register file and the switch sequencer.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ns

interface oscd_switch_if;
    logic       start;
    logic [2:0] target;
    logic [2:0] current;
    logic       pll_locked;
    logic       begin_sw;
    logic       done;
    logic       abort;

    modport ctrl (
        output start,
        output target,
        output current,
        output pll_locked,
        input  begin_sw,
        input  done,
        input  abort
    );

    modport seq (
        input  start,
        input  target,
        input  current,
        input  pll_locked,
        output begin_sw,
        output done,
        output abort
    );
endinterface

// ===== hdl/oscd_switch_seq.sv
// Clock switch sequencer: compares the requested with the current
// source, waits for PLL lock where needed, then settles and reports.
// Assumes start is a one-cycle pulse and inputs are on pclk.
`timescale 1ns/1ns
`include "oscd_regs.svh"

module oscd_switch_seq (
    input  wire logic  pclk,
    input  wire logic  presetn,
    oscd_switch_if.seq sw
);

    oscd_pkg::oscd_seq_t st_ff;
    oscd_pkg::oscd_seq_t nxt_st;
    logic                uses_pll;

    assign sw.begin_sw = st_ff.begin_sw;
    assign sw.done     = st_ff.done;
    assign sw.abort    = st_ff.abort;

    always_comb
    begin
        uses_pll = (sw.target == oscd_pkg::SRC_FAST_RC_PLL)
                || (sw.target == oscd_pkg::SRC_PRIMARY_PLL);
        nxt_st = st_ff;
        nxt_st.begin_sw = 1'b0;
        nxt_st.done = 1'b0;
        nxt_st.abort = 1'b0;
        unique case (st_ff.state)
            oscd_pkg::SW_IDLE:
            begin
                if (sw.start && (sw.target == sw.current))
                begin
                    nxt_st.abort = 1'b1;
                end
                else if (sw.start)
                begin
                    nxt_st.begin_sw = 1'b1;
                    nxt_st.cnt = 4'h0;
                    nxt_st.state = uses_pll ? oscd_pkg::SW_WAIT_LOCK
                                            : oscd_pkg::SW_SETTLE;
                end
            end
            oscd_pkg::SW_WAIT_LOCK:
            begin
                // The lock is a two-flop synchronised level, so any glitch
                // the first flop samples still reaches here, two cycles late.
                if (sw.pll_locked)
                begin
                    nxt_st.state = oscd_pkg::SW_SETTLE;
                end
            end
            oscd_pkg::SW_SETTLE:
            begin
                if (st_ff.cnt == `OSCD_SETTLE_CYCLES - 4'h1)
                begin
                    nxt_st.done = 1'b1;
                    nxt_st.state = oscd_pkg::SW_IDLE;
                end
                else
                begin
                    nxt_st.cnt = st_ff.cnt + 4'h1;
                end
            end
            default:
            begin
                nxt_st.state = oscd_pkg::SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '{state: oscd_pkg::SW_IDLE, default: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

endmodule

// ===== hdl/oscd_top.sv
// Oscillator select and clock divider register block with APB slave.
// Assumes static configuration fields, a same-clock interrupt level,
// and asynchronous PLL lock and clock-fail levels from the oscillators.
//
// Summary of operation
// - Power-on source from 3-bit configuration field.
// - Primary submode loaded from its field for every source.
// - Erased configuration means RC divide-by-N.
// - Current source readable at bits 14-12.
// - Requested source writable, loaded at power-on.
// - Clock lock bit blocks switching when 01.
// - Pin map lock blocks pin select writes.
// - PLL lock status reads lock or zero.
// - Clock fail flag set on failure, cleared.
// - Secondary oscillator enable follows bit 1.
// - Switch request set by software, self-clears.
// - Interrupt clears reduction enable when recovering.
// - Reduction ratio is two to field.
// - Reduction enable selects ratio or 1:1.
// - RC postscaler divide table from field.
// - PLL postscaler divides by 2, 4, 8.
// - PLL prescaler is field plus two.
// - PLL multiplier is field plus two.
// - Unimplemented bits read zero, ignore writes.
// - Instruction clock is oscillator divided by two.
// - PLL output is input times M/(N1*N2).
`timescale 1ns/1ns
`include "oscd_regs.svh"

module oscd_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic [11:0] paddr,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  initial_source_cfg,
    input  wire logic [1:0]  primary_submode_cfg,
    input  wire logic [1:0]  switch_monitor_cfg,
    input  wire logic        irq_pending,
    input  wire logic        pll_locked_in,
    input  wire logic        clock_fail_in,
    output logic      [2:0]  current_source,
    output logic      [1:0]  primary_submode,
    output logic             primary_selected,
    output logic             secondary_osc_on,
    output logic             pin_map_locked,
    output logic      [2:0]  reduction_shift,
    output logic      [8:0]  rc_div_factor,
    output logic      [5:0]  pll_n1,
    output logic      [3:0]  pll_n2,
    output logic      [9:0]  pll_m,
    output logic      [1:0]  fcy_div
);

    oscd_pkg::oscd_top_t st_ff;
    oscd_pkg::oscd_top_t nxt_st;
    oscd_switch_if       sw ();

    logic        setup;
    logic        wr_acc;
    logic        hit_osc;
    logic        hit_div;
    logic        hit_fbd;
    logic        sw_enabled;
    logic        sw_locked;
    logic        fail_rise;
    logic        pll_active;
    logic [31:0] rd_word;

    // ------------------------------------------------------------------
    // Switch sequencer
    // ------------------------------------------------------------------
    assign sw.start      = st_ff.go;
    assign sw.target     = st_ff.req_src;
    assign sw.current    = st_ff.cur_src;
    assign sw.pll_locked = st_ff.lock_sync[1];

    oscd_switch_seq u_seq (
        .pclk    (pclk),
        .presetn (presetn),
        .sw      (sw.seq)
    );

    // ------------------------------------------------------------------
    // Output wiring
    // ------------------------------------------------------------------
    assign prdata           = st_ff.prdata;
    assign pready           = st_ff.pready;
    assign pslverr          = st_ff.pslverr;
    assign current_source   = st_ff.cur_src;
    assign primary_submode  = st_ff.submode;
    assign primary_selected = st_ff.primary_sel;
    assign secondary_osc_on = st_ff.secondary_oscillator_en;
    assign pin_map_locked   = st_ff.pin_lock;
    assign reduction_shift  = st_ff.red_shift;
    assign rc_div_factor    = st_ff.rc_div;
    assign pll_n1           = st_ff.pll_n1;
    assign pll_n2           = st_ff.pll_n2;
    assign pll_m            = st_ff.pll_m;
    assign fcy_div          = st_ff.fcy_div;

    // ------------------------------------------------------------------
    // Divider lookups
    // ------------------------------------------------------------------
    function automatic logic [8:0] rc_factor(input logic [2:0] f);
        logic [8:0] r;
        r = 9'h001;
        unique case (f)
            3'h0: r = 9'h001;
            3'h1: r = 9'h002;
            3'h2: r = 9'h002;
            3'h3: r = 9'h008;
            3'h4: r = 9'h010;
            3'h5: r = 9'h020;
            3'h6: r = 9'h040;
            3'h7: r = 9'h100;
        endcase
        return r;
    endfunction

    // The reserved postscaler code keeps the default factor of four,
    // so the factor output always holds a legal divisor.
    function automatic logic [3:0] post_factor(input logic [1:0] f);
        logic [3:0] r;
        r = 4'h4;
        unique case (f)
            2'h0: r = 4'h2;
            2'h1: r = 4'h4;
            2'h2: r = 4'h4;
            2'h3: r = 4'h8;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Register file and status
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        setup   = psel && !penable && !st_ff.pready;
        wr_acc  = psel && penable && st_ff.pready && pwrite;
        hit_osc = paddr == `OSCD_OFF_OSC_CTRL;
        hit_div = paddr == `OSCD_OFF_CLK_DIV;
        hit_fbd = paddr == `OSCD_OFF_PLL_FBD;
        sw_enabled = !st_ff.sw_mon[1];
        sw_locked = st_ff.sw_lock
                 && (st_ff.sw_mon == `OSCD_SW_MON_LOCKABLE);
        fail_rise = st_ff.fail_sync[1] && !st_ff.fail_seen;
        pll_active = (st_ff.cur_src == oscd_pkg::SRC_FAST_RC_PLL)
                  || (st_ff.cur_src == oscd_pkg::SRC_PRIMARY_PLL);

        // Two flops ahead of any use of the asynchronous levels.
        nxt_st.lock_sync = {st_ff.lock_sync[0], pll_locked_in};
        nxt_st.fail_sync = {st_ff.fail_sync[0], clock_fail_in};
        nxt_st.fail_seen = st_ff.fail_sync[1];
        // Status lags the synchronised lock by one cycle; software
        // polls it, so the lag is harmless.
        // lock status, zero when PLL unused
        nxt_st.pll_lock = st_ff.lock_sync[1] && pll_active;
        nxt_st.go = 1'b0;

        // Switching reads as disabled until this load, so an early
        // request can never start a switch.
        // sample configuration after reset
        if (!st_ff.cfg_loaded)
        begin
            nxt_st.cfg_loaded = 1'b1;
            nxt_st.sw_mon = switch_monitor_cfg;
            nxt_st.submode = primary_submode_cfg;
            nxt_st.cur_src = initial_source_cfg;
            nxt_st.req_src = initial_source_cfg;
        end

        rd_word = 32'h0000_0000;
        if (hit_osc)
        begin
            rd_word[`OSCD_CUR_SRC_LSB +: 3] = st_ff.cur_src;
            rd_word[`OSCD_REQ_SRC_LSB +: 3] = st_ff.req_src;
            rd_word[`OSCD_SW_LOCK_BIT]  = st_ff.sw_lock;
            rd_word[`OSCD_PIN_LOCK_BIT] = st_ff.pin_lock;
            rd_word[`OSCD_PLL_LOCK_BIT] = st_ff.pll_lock;
            rd_word[`OSCD_FAIL_BIT]     = st_ff.fail;
            rd_word[`OSCD_SECONDARY_OSCILLATOR_EN_BIT]  = st_ff.secondary_oscillator_en;
            rd_word[`OSCD_SW_REQ_BIT]   = st_ff.sw_req;
        end
        else if (hit_div)
        begin
            rd_word[`OSCD_ROI_BIT]           = st_ff.recover_on_interrupt;
            rd_word[`OSCD_DOZE_LSB +: 3]     = st_ff.doze;
            rd_word[`OSCD_RED_EN_BIT]        = st_ff.red_en;
            rd_word[`OSCD_RC_POST_LSB +: 3]  = st_ff.rc_post;
            rd_word[`OSCD_PLL_POST_LSB +: 2] = st_ff.pll_post;
            rd_word[`OSCD_PLL_PRE_LSB +: 5]  = st_ff.pll_pre;
        end
        else if (hit_fbd)
        begin
            rd_word[8:0] = st_ff.pll_mul;
        end

        // Ready is raised in the setup cycle so every access ends after
        // exactly one access-phase cycle.
        nxt_st.pready = setup;
        if (setup)
        begin
            nxt_st.prdata = pwrite ? 32'h0000_0000 : rd_word;
            nxt_st.pslverr = !(hit_osc || hit_div || hit_fbd);
        end
        else
        begin
            nxt_st.pslverr = 1'b0;
        end

        // The lock test uses the stored lock bit: a write that sets
        // the lock together with a request still starts that switch.
        // Software sets the lock in a write of its own first.
        if (wr_acc && hit_osc)
        begin
            nxt_st.req_src = pwdata[`OSCD_REQ_SRC_LSB +: 3];
            nxt_st.sw_lock = pwdata[`OSCD_SW_LOCK_BIT];
            nxt_st.pin_lock = pwdata[`OSCD_PIN_LOCK_BIT];
            nxt_st.secondary_oscillator_en = pwdata[`OSCD_SECONDARY_OSCILLATOR_EN_BIT];
            if (!pwdata[`OSCD_FAIL_BIT])
            begin
                nxt_st.fail = 1'b0;
            end
            if (pwdata[`OSCD_SW_REQ_BIT] && !st_ff.sw_req
                && sw_enabled && !sw_locked && st_ff.cfg_loaded)
            begin
                nxt_st.sw_req = 1'b1;
                nxt_st.go = 1'b1;
            end
        end

        if (wr_acc && hit_div)
        begin
            nxt_st.recover_on_interrupt      = pwdata[`OSCD_ROI_BIT];
            nxt_st.doze     = pwdata[`OSCD_DOZE_LSB +: 3];
            nxt_st.red_en   = pwdata[`OSCD_RED_EN_BIT];
            nxt_st.rc_post  = pwdata[`OSCD_RC_POST_LSB +: 3];
            nxt_st.pll_post = pwdata[`OSCD_PLL_POST_LSB +: 2];
            nxt_st.pll_pre  = pwdata[`OSCD_PLL_PRE_LSB +: 5];
        end

        if (wr_acc && hit_fbd)
        begin
            nxt_st.pll_mul = pwdata[8:0];
        end

        if (st_ff.recover_on_interrupt && irq_pending)
        begin
            nxt_st.red_en = 1'b0;
        end

        if (sw.done)
        begin
            nxt_st.sw_req = 1'b0;
            nxt_st.cur_src = st_ff.req_src;
        end
        if (sw.abort)
        begin
            nxt_st.sw_req = 1'b0;
        end
        // Clears come before the set so a failure edge always wins.
        // valid switch clears, new failure wins
        if (sw.begin_sw)
        begin
            nxt_st.fail = 1'b0;
        end
        if (fail_rise)
        begin
            nxt_st.fail = 1'b1;
        end

        nxt_st.primary_sel = (st_ff.cur_src == oscd_pkg::SRC_PRIMARY)
                          || (st_ff.cur_src == oscd_pkg::SRC_PRIMARY_PLL);
        // divide by two to the field
        nxt_st.red_shift = st_ff.red_en ? st_ff.doze : 3'h0;
        nxt_st.rc_div = rc_factor(st_ff.rc_post);
        nxt_st.pll_n2 = post_factor(st_ff.pll_post);
        nxt_st.pll_n1 = {1'b0, st_ff.pll_pre} + 6'h02;
        nxt_st.pll_m = {1'b0, st_ff.pll_mul} + 10'h002;
        nxt_st.fcy_div = `OSCD_FCY_DIV;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Factor outputs start at what the reset fields imply.
            st_ff <= '0;
            st_ff.cur_src   <= `OSCD_RST_SRC;
            st_ff.req_src   <= `OSCD_RST_SRC;
            st_ff.sw_mon    <= 2'h3;
            st_ff.doze      <= `OSCD_RST_DOZE;
            st_ff.rc_post   <= `OSCD_RST_RC_POST;
            st_ff.pll_post  <= `OSCD_RST_PLL_POST;
            st_ff.pll_pre   <= `OSCD_RST_PLL_PRE;
            st_ff.pll_mul   <= `OSCD_RST_PLL_MUL;
            st_ff.rc_div    <= 9'h001;
            st_ff.red_shift <= 3'h0;
            st_ff.pll_n1    <= 6'h02;
            st_ff.pll_n2    <= 4'h4;
            st_ff.pll_m     <= 10'h032;
            st_ff.fcy_div   <= `OSCD_FCY_DIV;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

endmodule

// ===== testbench/oscd_top_sva.sv
// Checker for the APB handshake and divider outputs of oscd_top.
// Assumes one pclk domain and the register map of oscd_regs.svh.
`timescale 1ns/1ns
`include "oscd_regs.svh"

module oscd_top_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [8:0]  rc_div_factor,
    input wire logic [5:0]  pll_n1,
    input wire logic [3:0]  pll_n2,
    input wire logic [9:0]  pll_m,
    input wire logic [1:0]  fcy_div
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire acc = psel && penable && pready;
    wire map = paddr inside {`OSCD_OFF_OSC_CTRL, `OSCD_OFF_CLK_DIV,
                             `OSCD_OFF_PLL_FBD};

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_unmapped: assert property (acc && !map |-> pslverr)
        else $error("no error on unmapped address");
    a_ok_mapped: assert property (acc && map |-> !pslverr)
        else $error("error on mapped address");
    a_osc_unimpl: assert property (
        acc && !pwrite && paddr == `OSCD_OFF_OSC_CTRL
        |-> (prdata & 32'hffff_8814) == 32'h0)
        else $error("control register spare bits set");
    a_fbd_unimpl: assert property (
        acc && !pwrite && paddr == `OSCD_OFF_PLL_FBD
        |-> (prdata & 32'hffff_fe00) == 32'h0)
        else $error("feedback register spare bits set");
    a_pre_follows: assert property (
        acc && pwrite && paddr == `OSCD_OFF_CLK_DIV
        |=> ##1 pll_n1 == $past(pwdata[4:0], 2) + 6'h2)
        else $error("prescale factor wrong");
    a_mul_follows: assert property (
        acc && pwrite && paddr == `OSCD_OFF_PLL_FBD
        |=> ##1 pll_m == $past(pwdata[8:0], 2) + 10'h2)
        else $error("multiplier wrong");
    a_post_legal: assert property (
        pll_n2 inside {4'h2, 4'h4, 4'h8})
        else $error("postscale factor illegal");
    a_rc_legal: assert property (
        rc_div_factor inside {9'h1, 9'h2, 9'h8, 9'h10, 9'h20, 9'h40, 9'h100})
        else $error("rc divisor illegal");
    a_fcy_half: assert property (fcy_div == `OSCD_FCY_DIV)
        else $error("instruction clock divisor wrong");

    c_write: cover property (acc && pwrite && map);
    c_unmapped: cover property (acc && !map);
    c_mul_change: cover property (acc && pwrite && paddr == `OSCD_OFF_PLL_FBD);
endmodule

bind oscd_top oscd_top_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rc_div_factor(rc_div_factor),
    .pll_n1(pll_n1), .pll_n2(pll_n2), .pll_m(pll_m), .fcy_div(fcy_div)
);

// ===== testbench/test_oscd_top.sv
// Self-checking bench for oscd_top, driving its APB and status pins.
// Assumes the hdl/ files are compiled first.
`timescale 1ns/1ns
`include "oscd_regs.svh"
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    n_fail++; $display("mismatch %s expected %h seen %h", nm, e, s); \
    end end

module test_oscd_top;
    localparam logic [11:0] OSC = `OSCD_OFF_OSC_CTRL;
    localparam logic [11:0] DIV = `OSCD_OFF_CLK_DIV;
    localparam logic [11:0] FBD = `OSCD_OFF_PLL_FBD;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, irq_pending = 1'b0, er;
    logic        pll_locked_in = 1'b0, clock_fail_in = 1'b0;
    logic        pready, pslverr, primary_selected, secondary_osc_on;
    logic        pin_map_locked;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic [2:0]  initial_source_cfg = 3'h7, current_source, reduction_shift;
    logic [1:0]  primary_submode_cfg = 2'h0, switch_monitor_cfg = 2'h1;
    logic [1:0]  primary_submode, fcy_div;
    logic [8:0]  rc_div_factor;
    logic [5:0]  pll_n1;
    logic [3:0]  pll_n2;
    logic [9:0]  pll_m;
    int          n_fail = 0, samples_checked = 0;

    oscd_top u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .initial_source_cfg(initial_source_cfg),
        .primary_submode_cfg(primary_submode_cfg),
        .switch_monitor_cfg(switch_monitor_cfg), .irq_pending(irq_pending),
        .pll_locked_in(pll_locked_in), .clock_fail_in(clock_fail_in),
        .current_source(current_source), .primary_submode(primary_submode),
        .primary_selected(primary_selected),
        .secondary_osc_on(secondary_osc_on), .pin_map_locked(pin_map_locked),
        .reduction_shift(reduction_shift), .rc_div_factor(rc_div_factor),
        .pll_n1(pll_n1), .pll_n2(pll_n2), .pll_m(pll_m), .fcy_div(fcy_div)
    );

    initial forever #25 pclk = ~pclk;

    task automatic close_out;
        if (n_fail == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One APB transfer; the bench waits on pready under a bound.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] v);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20)
        begin
            n_fail++;
            close_out();
        end
    endtask

    // Reads the control register until the switch request bit drops.
    task automatic poll;
        int k;
        k = 0;
        rd = 32'h1;
        while (rd[0] === 1'b1 && k < 40)
        begin
            apb(1'b0, OSC, 32'h0);
            k++;
        end
        if (k >= 40)
        begin
            n_fail++;
            close_out();
        end
    endtask

    task automatic rst(input logic [2:0] c);
        initial_source_cfg <= c;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    function automatic logic [8:0] exp_rc(input logic [2:0] f);
        return (f == 3'h2) ? 9'h2 : 9'h1 << ((f == 3'h7) ? 4'h8 : {1'b0, f});
    endfunction

    initial
    begin
        void'($urandom(32'h4ee9e34c));
        repeat (2) @(posedge pclk);
        for (int c = 0; c < 8; c++)
        begin
            primary_submode_cfg <= 2'($urandom);
            rst(3'(c));
            apb(1'b0, OSC, 32'h0);
            `CHK("osc", {17'h0, 3'(c), 1'b0, 3'(c), 8'h0}, rd)
            `CHK("cur", 3'(c), current_source)
            `CHK("psel", 1'(c == 2 || c == 3), primary_selected)
            if (c == 2 || c == 3)
                `CHK("sub", primary_submode_cfg, primary_submode)
        end
        apb(1'b0, DIV, 32'h0);
        `CHK("div rst", 32'h3040, rd)
        `CHK("fbd rst", 10'd50, pll_m)
        for (int i = 0; i < 12; i++)
        begin
            d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom;
            apb(1'b1, DIV, d);
            apb(1'b0, DIV, 32'h0);
            `CHK("div", d & 32'hffdf, rd)
            apb(1'b1, FBD, d);
            apb(1'b0, FBD, 32'h0);
            `CHK("fbd", d & 32'h1ff, rd)
            repeat (3) @(posedge pclk);
            `CHK("n1", {1'b0, d[4:0]} + 6'h2, pll_n1)
            `CHK("n2", !d[7:6] ? 4'h2 : &d[7:6] ? 4'h8 : 4'h4, pll_n2)
            `CHK("rc", exp_rc(d[10:8]), rc_div_factor)
            `CHK("red", d[11] ? d[14:12] : 3'h0, reduction_shift)
            `CHK("m", {1'b0, d[8:0]} + 10'h2, pll_m)
            d = $urandom & 32'hfffe;
            apb(1'b1, OSC, d);
            apb(1'b0, OSC, 32'h0);
            `CHK("osc", 32'h7000 | (d & 32'h7c2), rd)
            repeat (3) @(posedge pclk);
            `CHK("pin", d[6], pin_map_locked)
            `CHK("secondary_oscillator", d[1], secondary_osc_on)
        end
        // switch, redundant switch, then locked refusal
        apb(1'b1, OSC, 32'h0);
        for (int j = 0; j < 2; j++)
        begin
            apb(1'b1, OSC, 32'h0001);
            poll();
            `CHK("sw", 32'h0, rd & 32'h7001)
        end
        `CHK("cur", 3'h0, current_source)
        apb(1'b1, OSC, 32'h0480);
        apb(1'b1, OSC, 32'h0481);
        repeat (20) @(posedge pclk);
        apb(1'b0, OSC, 32'h0);
        `CHK("lock", 32'h0480, rd & 32'h7481)
        pll_locked_in <= 1'b1;
        apb(1'b1, OSC, 32'h0100);
        apb(1'b1, OSC, 32'h0101);
        poll();
        apb(1'b0, OSC, 32'h0);
        `CHK("pll", 32'h1020, rd & 32'h7021)
        pll_locked_in <= 1'b0;
        repeat (5) @(posedge pclk);
        apb(1'b0, OSC, 32'h0);
        `CHK("unlk", 1'b0, rd[5])
        clock_fail_in <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, OSC, 32'h0);
        `CHK("cf", 1'b1, rd[3])
        clock_fail_in <= 1'b0;
        apb(1'b1, OSC, rd & 32'hfff6);
        apb(1'b0, OSC, 32'h0);
        `CHK("cf clr", 1'b0, rd[3])
        // interrupt recovery with and without the recover bit
        for (int r = 0; r < 2; r++)
        begin
            apb(1'b1, DIV, r ? 32'h5800 : 32'hd800);
            irq_pending <= 1'b1;
            @(posedge pclk);
            irq_pending <= 1'b0;
            apb(1'b0, DIV, 32'h0);
            repeat (3) @(posedge pclk);
            `CHK("roi", 1'(r), rd[11])
            `CHK("dz", r ? 3'h5 : 3'h0, reduction_shift)
        end
        apb(1'b1, 12'h00c, $urandom);
        `CHK("err", 1'b1, er)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("err rd", 33'h1_0000_0000, {er, rd})
        close_out();
    end
endmodule
